// >>> shared/pfi_pkg.sv
// Operation
// - Filter read index shows in control/status bits 15:12.
// - Filter off: each entry port read advances read index by one.
// - Turning the filter on forces the read index to zero.
// - Filter on: entry port reads leave the read index alone.
// - Filter write index shows in control/status bits 11:8.
// - Filter off: each entry port write advances write index by one.
// - Bits 6:4 report the buffer receiving currently selected stream packets.
// - Clear bit zeroes all comparison values and both filter indices.
// - Filter on: only packets whose PID matches an entry are buffered.
// - Filter off: every packet passes unfiltered.
// - Insertion off: RAM port write stores data at insertion write index.
// - Before insertion is on, each RAM port write advances write index.
// - Insertion on: RAM port accesses change neither RAM nor indices.
// - Insertion RAM is not cleared by reset.
// - Reserved control/status bits ignore writes and read as zero.
// - Entry port reads give entry at read index; writes only when off.
// - Insertion write index reads in insertion control bits 29:24.
package pfi_pkg;

   localparam int          PFI_ADDR_W       = 12;
   localparam int          PFI_DATA_W       = 32;
   localparam int          PFI_ENTRIES      = 16;
   localparam int          PFI_IDX_W        = 4;
   localparam int          PFI_INS_IDX_W    = 6;
   localparam int          PFI_INS_DEPTH    = 64;
   localparam int          PFI_BUF_W        = 3;
   localparam int          PFI_FIFO_DEPTH   = 8;

   localparam logic [11:0] PFI_OFS_ENTRY    = 12'h09c;
   localparam logic [11:0] PFI_OFS_CSR      = 12'h0a0;
   localparam logic [11:0] PFI_OFS_INS_PORT = 12'h0a4;
   localparam logic [11:0] PFI_OFS_INS_CTRL = 12'h0a8;

   localparam int          PFI_CSR_RD_LSB   = 12;
   localparam int          PFI_CSR_WR_LSB   = 8;
   localparam int          PFI_CSR_BUF_LSB  = 4;
   localparam int          PFI_CSR_CLR_BIT  = 1;
   localparam int          PFI_CSR_ON_BIT   = 0;
   localparam int          PFI_INS_WR_LSB   = 24;
   localparam int          PFI_INS_RD_LSB   = 16;
   localparam int          PFI_INS_ON_BIT   = 6;

   localparam int          PFI_PID_LSB      = 8;
   localparam int          PFI_PID_W        = 13;

   localparam logic [31:0] PFI_ZERO_WORD    = 32'h0000_0000;

   typedef enum logic [1:0] {
      PFI_PKT_WAIT,
      PFI_PKT_PASS,
      PFI_PKT_DROP
   } pfi_pkt_type;

   function automatic logic [PFI_IDX_W-1:0] pfi_inc_idx(input logic [PFI_IDX_W-1:0] v);
      pfi_inc_idx = v + 4'h1;
   endfunction

   function automatic logic [PFI_INS_IDX_W-1:0] pfi_inc_ins(input logic [PFI_INS_IDX_W-1:0] v);
      pfi_inc_ins = v + 6'h01;
   endfunction

endpackage

// >>> logic/pfi_fifo.sv
`timescale 1ns/1ps
module pfi_fifo
   import pfi_pkg::*;
#(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   input  wire logic                       ref_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH+1)-1:0]      level
);
   localparam int PW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [LW-1:0]               count;
   } pfi_fifo_state_type;

   pfi_fifo_state_type s_q;
   pfi_fifo_state_type s_d;
   logic               push;
   logic               pop;

   assign in_ready  = (s_q.count != LW'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data  = s_q.mem[s_q.rd_ptr];
   assign level     = s_q.count;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data;
         s_d.wr_ptr = (s_q.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + PW'(1);
      end
      if (pop) begin
         s_d.rd_ptr = (s_q.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + PW'(1);
      end
      s_d.count = s_q.count + LW'(push) - LW'(pop);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// >>> logic/pfi_filter_regs.sv
`timescale 1ns/1ps
module pfi_filter_regs
   import pfi_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   sys_rst,
   input  wire logic [PFI_ADDR_W-1:0]  host_addr,
   input  wire logic                   host_wr,
   input  wire logic                   host_rd,
   input  wire logic [31:0]            host_wdata,
   output logic [31:0]                 host_rdata,
   output logic                        host_rvalid,
   input  wire logic [47:0]            entry_buf_map,
   input  wire logic                   insert_done,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [31:0]            in_data,
   input  wire logic                   in_first,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [31:0]                 out_data,
   output logic                        out_first,
   output logic [PFI_BUF_W-1:0]        out_buf
);
   localparam int FW = PFI_DATA_W + 1 + PFI_BUF_W;
   localparam int LW = $clog2(PFI_FIFO_DEPTH + 1);

   typedef struct packed {
      logic [PFI_ENTRIES-1:0][31:0] entry;
      logic [PFI_IDX_W-1:0]         rd_idx;
      logic [PFI_IDX_W-1:0]         wr_idx;
      logic [PFI_BUF_W-1:0]         sel_buf;
      logic                         on;
      logic                         ins_on;
      logic [PFI_INS_IDX_W-1:0]     ins_wr;
      logic [PFI_INS_IDX_W-1:0]     ins_rd;
      pfi_pkt_type                  pkt;
      logic                         in_ready;
      logic                         out_valid;
      logic [31:0]                  out_data;
      logic                         out_first;
      logic [PFI_BUF_W-1:0]         out_buf;
      logic [31:0]                  rdata;
      logic                         rvalid;
   } pfi_state_type;

   pfi_state_type          s_q;
   pfi_state_type          s_d;
   logic [31:0]            ins_ram [PFI_INS_DEPTH];
   logic [31:0]            ins_rdata;
   logic                   wr_entry;
   logic                   rd_entry;
   logic                   wr_csr;
   logic                   wr_ins;
   logic                   rd_ins;
   logic                   wr_ins_ctrl;
   logic                   accept;
   logic                   hit;
   logic [PFI_BUF_W-1:0]   hit_buf;
   logic                   pass;
   logic                   fifo_push;
   logic                   fifo_out_valid;
   logic                   fifo_out_ready;
   logic [FW-1:0]          fifo_out_data;
   logic [LW-1:0]          fifo_level;
   logic [LW-1:0]          level_next;

   assign wr_entry    = host_wr && (host_addr == PFI_OFS_ENTRY);
   assign rd_entry    = host_rd && (host_addr == PFI_OFS_ENTRY);
   assign wr_csr      = host_wr && (host_addr == PFI_OFS_CSR);
   assign wr_ins      = host_wr && (host_addr == PFI_OFS_INS_PORT);
   assign rd_ins      = host_rd && (host_addr == PFI_OFS_INS_PORT);
   assign wr_ins_ctrl = host_wr && (host_addr == PFI_OFS_INS_CTRL);
   assign accept      = in_valid && s_q.in_ready;

   // PID compare; lowest matching entry decides the buffer
   always_comb begin
      hit     = 1'b0;
      hit_buf = '0;
      for (int i = PFI_ENTRIES - 1; i >= 0; i--) begin
         if (s_q.entry[i][PFI_PID_W-1:0] == in_data[PFI_PID_LSB +: PFI_PID_W]) begin
            hit     = 1'b1;
            hit_buf = entry_buf_map[i*PFI_BUF_W +: PFI_BUF_W];
         end
      end
   end

   always_comb begin
      if (in_first) begin
         pass = !s_q.on || hit;
      end else begin
         pass = (s_q.pkt == PFI_PKT_PASS);
      end
   end

   assign fifo_push      = accept && pass;
   assign fifo_out_ready = !s_q.out_valid || out_ready;
   assign level_next     = fifo_level + LW'(fifo_push) - LW'(fifo_out_valid && fifo_out_ready);

   // Insertion RAM has no reset so it maps onto plain memory
   always_ff @(posedge ref_clk) begin
      if (wr_ins && !s_q.ins_on) begin
         ins_ram[s_q.ins_wr] <= host_wdata;
      end
   end

   assign ins_rdata = ins_ram[s_q.ins_rd];

   always_comb begin
      s_d        = s_q;
      s_d.rvalid = 1'b0;

      if (wr_entry && !s_q.on) begin
         s_d.entry[s_q.wr_idx] = host_wdata;
         s_d.wr_idx = pfi_inc_idx(s_q.wr_idx);
      end
      if (rd_entry && !s_q.on) begin
         s_d.rd_idx = pfi_inc_idx(s_q.rd_idx);
      end

      if (wr_csr) begin
         // Only the enable is stored; reserved bits are dropped
         s_d.on = host_wdata[PFI_CSR_ON_BIT];
         if (host_wdata[PFI_CSR_ON_BIT] && !s_q.on) begin
            s_d.rd_idx = '0;
         end
         if (host_wdata[PFI_CSR_CLR_BIT]) begin
            s_d.entry  = '0;
            s_d.rd_idx = '0;
            s_d.wr_idx = '0;
         end
      end

      if (!s_q.ins_on) begin
         if (wr_ins) begin
            s_d.ins_wr = pfi_inc_ins(s_q.ins_wr);
         end
         if (rd_ins) begin
            s_d.ins_rd = pfi_inc_ins(s_q.ins_rd);
         end
      end
      if (insert_done) begin
         s_d.ins_on = 1'b0;
      end
      // A host set is ignored while insertion is on, so a completion in the same cycle wins
      if (wr_ins_ctrl && host_wdata[PFI_INS_ON_BIT] && !s_q.ins_on) begin
         s_d.ins_on = 1'b1;
         s_d.ins_wr = '0;
         s_d.ins_rd = '0;
      end

      if (host_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = PFI_ZERO_WORD;
         unique case (host_addr)
            PFI_OFS_ENTRY: begin
               s_d.rdata = s_q.entry[s_q.rd_idx];
            end
            PFI_OFS_CSR: begin
               s_d.rdata[PFI_CSR_RD_LSB +: PFI_IDX_W]  = s_q.rd_idx;
               s_d.rdata[PFI_CSR_WR_LSB +: PFI_IDX_W]  = s_q.wr_idx;
               s_d.rdata[PFI_CSR_BUF_LSB +: PFI_BUF_W] = s_q.sel_buf;
               s_d.rdata[PFI_CSR_ON_BIT]               = s_q.on;
            end
            PFI_OFS_INS_PORT: begin
               s_d.rdata = ins_rdata;
            end
            PFI_OFS_INS_CTRL: begin
               s_d.rdata[PFI_INS_WR_LSB +: PFI_INS_IDX_W] = s_q.ins_wr;
               s_d.rdata[PFI_INS_RD_LSB +: PFI_INS_IDX_W] = s_q.ins_rd;
               s_d.rdata[PFI_INS_ON_BIT]                  = s_q.ins_on;
            end
            default: begin
               s_d.rdata = PFI_ZERO_WORD;
            end
         endcase
      end

      if (accept && in_first) begin
         s_d.pkt = pass ? PFI_PKT_PASS : PFI_PKT_DROP;
         if (s_q.on && hit) begin
            s_d.sel_buf = hit_buf;
         end
      end

      if (fifo_out_valid && fifo_out_ready) begin
         s_d.out_valid = 1'b1;
         {s_d.out_first, s_d.out_buf, s_d.out_data} = fifo_out_data;
      end else if (out_ready) begin
         s_d.out_valid = 1'b0;
      end

      // Registered ready looks one push ahead so the FIFO never overflows
      s_d.in_ready = (level_next < LW'(PFI_FIFO_DEPTH - 1)) ||
                     ((level_next == LW'(PFI_FIFO_DEPTH - 1)) && !fifo_push);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   pfi_fifo #(
      .WIDTH (FW),
      .DEPTH (PFI_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .in_valid  (fifo_push),
      .in_ready  (),
      .in_data   ({in_first, (s_q.on ? (in_first ? hit_buf : s_q.sel_buf) : s_q.sel_buf), in_data}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   assign host_rdata  = s_q.rdata;
   assign host_rvalid = s_q.rvalid;
   assign in_ready    = s_q.in_ready;
   assign out_valid   = s_q.out_valid;
   assign out_data    = s_q.out_data;
   assign out_first   = s_q.out_first;
   assign out_buf     = s_q.out_buf;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   rd_index_step_a: assert property (
      rd_entry && !s_q.on && !host_wr |=> s_q.rd_idx == $past(s_q.rd_idx) + 4'h1)
      else $error("read index did not advance");

   rd_index_zero_a: assert property (
      $rose(s_q.on) |-> s_q.rd_idx == '0)
      else $error("read index not zero after enable");

   rd_index_hold_a: assert property (
      rd_entry && s_q.on && !host_wr |=> $stable(s_q.rd_idx))
      else $error("read index moved while filter on");

   wr_index_step_a: assert property (
      wr_entry && !s_q.on |=> s_q.wr_idx == $past(s_q.wr_idx) + 4'h1)
      else $error("write index did not advance");

   clear_all_a: assert property (
      wr_csr && host_wdata[PFI_CSR_CLR_BIT] |=> s_q.rd_idx == '0 && s_q.wr_idx == '0 && s_q.entry == '0)
      else $error("clear left state behind");

   clear_reads_zero_a: assert property (
      host_rd && host_addr == PFI_OFS_CSR |=> host_rvalid && !host_rdata[PFI_CSR_CLR_BIT])
      else $error("clear bit reads back set");

   csr_reserved_a: assert property (
      host_rd && host_addr == PFI_OFS_CSR |=> host_rdata[31:16] == '0 && !host_rdata[7] && host_rdata[3:2] == '0)
      else $error("reserved bits not zero");

   ins_index_step_a: assert property (
      wr_ins && !s_q.ins_on && !wr_ins_ctrl |=> s_q.ins_wr == $past(s_q.ins_wr) + 6'h01)
      else $error("insertion index did not advance");

   ins_port_lock_a: assert property (
      (wr_ins || rd_ins) && s_q.ins_on |=> $stable(s_q.ins_wr) && $stable(s_q.ins_rd))
      else $error("insertion index moved while on");

   filter_drop_a: assert property (
      accept && in_first && s_q.on && !hit |-> !fifo_push ##1 s_q.pkt == PFI_PKT_DROP)
      else $error("unmatched packet passed");

   filter_bypass_a: assert property (
      accept && !s_q.on && (in_first || s_q.pkt == PFI_PKT_PASS) |-> fifo_push)
      else $error("packet dropped while filter off");

endmodule

// >>> tb/tb_pfi_filter_regs.sv
`timescale 1ns/1ps
module tb_pfi_filter_regs
   import pfi_pkg::*;
;
   logic        ref_clk       = 1'b0;
   logic        sys_rst       = 1'b1;
   logic [11:0] host_addr     = 12'h000;
   logic        host_wr       = 1'b0;
   logic        host_rd       = 1'b0;
   logic [31:0] host_wdata    = 32'h0000_0000;
   logic [31:0] host_rdata;
   logic        host_rvalid;
   logic [47:0] entry_buf_map = 48'h0;
   logic        insert_done   = 1'b0;
   logic        in_valid      = 1'b0;
   logic        in_ready;
   logic [31:0] in_data       = 32'h0000_0000;
   logic        in_first      = 1'b0;
   logic        out_valid;
   logic        out_ready     = 1'b1;
   logic [31:0] out_data;
   logic        out_first;
   logic [2:0]  out_buf;
   int          bad_count     = 0;
   int          comparisons   = 0;
   logic [35:0] outq[$];
   logic [31:0] v;

   pfi_filter_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .entry_buf_map(entry_buf_map), .insert_done(insert_done), .in_valid(in_valid), .in_ready(in_ready),
      .in_data(in_data), .in_first(in_first), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_first(out_first), .out_buf(out_buf));

   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   // Old values seen here, so no race with the output registers
   always @(posedge ref_clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) outq.push_back({out_buf, out_first, out_data});
   end

   function automatic logic [2:0] bmap(input int i);
      bmap = i[2:0] ^ 3'h5;
   endfunction

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_out(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic hwrite(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      host_addr <= a;
      host_wdata <= d;
      host_wr <= 1'b1;
      @(posedge ref_clk);
      host_wr <= 1'b0;
   endtask

   task automatic hread(input logic [11:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      host_addr <= a;
      host_rd <= 1'b1;
      @(posedge ref_clk);
      host_rd <= 1'b0;
      #1;
      d = host_rvalid ? host_rdata : ~host_rdata;
   endtask

   task automatic send(input logic [31:0] d, input logic f);
      logic ok;
      @(posedge ref_clk);
      in_valid <= 1'b1;
      in_data <= d;
      in_first <= f;
      for (int k = 0; k < 50; k++) begin
         #1 ok = in_ready;
         @(posedge ref_clk);
         if (ok) break;
      end
      in_valid <= 1'b0;
   endtask

   task automatic pop_chk(input logic [35:0] exp);
      for (int k = 0; k < 50 && outq.size() == 0; k++) @(posedge ref_clk);
      if (outq.size() == 0) chk_out(~exp, exp);
      else chk_out(outq.pop_front(), exp);
   endtask

   task automatic t_reset;
      hread(PFI_OFS_CSR, v);
      chk_reg(v, 32'h0000_0000);
      hread(PFI_OFS_INS_CTRL, v);
      chk_reg(v & 32'h3f3f_0040, 32'h0000_0000);
   endtask

   task automatic t_entries;
      for (int i = 0; i < 16; i++) begin
         hwrite(PFI_OFS_ENTRY, 32'h0000_0100 + i);
         hread(PFI_OFS_CSR, v);
         chk_reg(v, {16'h0, 4'h0, 4'(i + 1), 8'h00});
      end
      for (int i = 0; i < 16; i++) begin
         hread(PFI_OFS_ENTRY, v);
         chk_reg(v, 32'h0000_0100 + i);
         hread(PFI_OFS_CSR, v);
         chk_reg(v, {16'h0, 4'(i + 1), 4'h0, 8'h00});
      end
      hread(PFI_OFS_ENTRY, v);
   endtask

   task automatic t_enable;
      hwrite(PFI_OFS_CSR, 32'h0000_0001);
      hread(PFI_OFS_CSR, v);
      chk_reg(v, 32'h0000_0001);
      hread(PFI_OFS_ENTRY, v);
      chk_reg(v, 32'h0000_0100);
      hwrite(PFI_OFS_ENTRY, 32'h0000_1fff);
      hread(PFI_OFS_ENTRY, v);
      chk_reg(v, 32'h0000_0100);
      hread(PFI_OFS_CSR, v);
      chk_reg(v, 32'h0000_0001);
   endtask

   task automatic t_filter;
      send(32'h0001_05aa, 1'b1);
      send(32'h1234_5678, 1'b0);
      send(32'h0001_f0aa, 1'b1);
      send(32'h0bad_0bad, 1'b0);
      send(32'h0001_0c55, 1'b1);
      send(32'h8765_4321, 1'b0);
      pop_chk({bmap(5), 1'b1, 32'h0001_05aa});
      pop_chk({bmap(5), 1'b0, 32'h1234_5678});
      pop_chk({bmap(12), 1'b1, 32'h0001_0c55});
      pop_chk({bmap(12), 1'b0, 32'h8765_4321});
      repeat (10) @(posedge ref_clk);
      chk_reg(32'(outq.size()), 32'h0000_0000);
      hread(PFI_OFS_CSR, v);
      chk_reg(v, {24'h0, 1'b0, bmap(12), 4'h1});
   endtask

   task automatic t_fill;
      int   n;
      logic ok;
      n = 0;
      hwrite(PFI_OFS_CSR, 32'h0000_0000);
      @(posedge ref_clk);
      out_ready <= 1'b0;
      in_valid <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         in_data <= 32'h0001_f000 + i;
         in_first <= (i == 0);
         #1 ok = in_ready;
         @(posedge ref_clk);
         if (!ok) break;
         n++;
      end
      in_valid <= 1'b0;
      out_ready <= 1'b1;
      chk_reg(32'(n >= 8 && n < 20), 32'h0000_0001);
      // Unmatched PID on the head word still passes with the filter off
      for (int i = 0; i < n; i++) pop_chk({bmap(12), i == 0, 32'h0001_f000 + i});
   endtask

   task automatic t_clear;
      hwrite(PFI_OFS_ENTRY, 32'h0000_0aaa);
      hwrite(PFI_OFS_ENTRY, 32'h0000_0bbb);
      // Move the read index off zero so the clear has work to do
      hread(PFI_OFS_ENTRY, v);
      chk_reg(v, 32'h0000_0aaa);
      hwrite(PFI_OFS_CSR, 32'hffff_ff8e);
      hread(PFI_OFS_CSR, v);
      chk_reg(v & 32'hffff_ff8f, 32'h0000_0000);
      hread(PFI_OFS_ENTRY, v);
      chk_reg(v, 32'h0000_0000);
      hread(PFI_OFS_ENTRY, v);
      chk_reg(v, 32'h0000_0000);
   endtask

   task automatic t_insert;
      for (int i = 0; i < 3; i++) hwrite(PFI_OFS_INS_PORT, 32'hc0de_0000 + i);
      hread(PFI_OFS_INS_CTRL, v);
      chk_reg(v & 32'h3f00_0040, 32'h0300_0000);
      for (int i = 0; i < 3; i++) begin
         hread(PFI_OFS_INS_PORT, v);
         chk_reg(v, 32'hc0de_0000 + i);
      end
      hwrite(PFI_OFS_INS_CTRL, 32'h0000_0040);
      hwrite(PFI_OFS_INS_PORT, 32'hdead_beef);
      hread(PFI_OFS_INS_PORT, v);
      hread(PFI_OFS_INS_CTRL, v);
      chk_reg(v & 32'h3f3f_0040, 32'h0000_0040);
      @(posedge ref_clk);
      insert_done <= 1'b1;
      @(posedge ref_clk);
      insert_done <= 1'b0;
      hread(PFI_OFS_INS_PORT, v);
      chk_reg(v, 32'hc0de_0000);
      hread(PFI_OFS_INS_CTRL, v);
      chk_reg(v & 32'h3f3f_0040, 32'h0001_0000);
   endtask

   initial begin
      #50000;
      bad_count++;
      close_out();
   end

   initial begin
      @(posedge ref_clk);
      for (int i = 0; i < 16; i++) entry_buf_map[3*i +: 3] <= bmap(i);
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_reset();
      t_entries();
      t_enable();
      t_filter();
      t_fill();
      t_clear();
      t_insert();
      close_out();
   end
endmodule
